// [verilog/scb_pkg.sv]
package scb_pkg;

  // Open-drain pin drive: out is always low, oe pulls the wire
  typedef struct packed {
    logic out;
    logic oe;
  } scb_od_t;

  // Synchronised view of the upstream bus
  typedef struct packed {
    logic scl;
    logic sda;
  } scb_bus_t;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_PTR, S_PACK, S_WDATA, S_WACK, S_RDATA, S_RACK, S_FWD, S_IGN
  } scb_state_t;

  localparam int         STRAP_W      = 3;
  localparam int         ADDR_W       = 7;
  localparam int         BYTE_W       = 8;
  localparam int         REG_N        = 4;
  localparam logic [6:0] STRAP_BASE   = 7'h0c;
  localparam logic [6:0] STRAP_STEP   = 7'h02;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;

  // Register offsets on the serial bus, and the register reset value
  localparam logic [7:0] REG_ID       = 8'h00;
  localparam logic [7:0] REG_ALIAS    = 8'h08;
  localparam logic [7:0] REG_TARGET   = 8'h09;
  localparam logic [7:0] REG_FWD      = 8'h0a;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // Register indexes
  localparam logic [1:0] IX_ID        = 2'h0;
  localparam logic [1:0] IX_ALIAS     = 2'h1;
  localparam logic [1:0] IX_TARGET    = 2'h2;
  localparam logic [1:0] IX_FWD       = 2'h3;

  localparam int         ID_SEL_BIT   = 0;
  localparam int         FWD_EN_BIT   = 0;

endpackage

// [verilog/scb_sync.sv]
module scb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;

  // Two-flop synchroniser, pins idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage <= '1;
      dout  <= '1;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// [verilog/scb_serial_control_bus_slave.sv]
// Overview of operation
// - Own bus address comes from the strap pin, one of eight choices.
// - Strap levels map upward to even addresses 0x0C..0x1A; 8-bit form up to 0x34.
// - Matching address is acknowledged by pulling data low in the ack bit.
// - With forwarding off, a mismatching address gets no ack, data released, rest of transfer ignored.
// - Every write data byte received is acknowledged.
// - Read continues while master acks; master nack then stop releases the bus.
// - Transfers open with start, close with stop; both reset transfer state.
// - Bus lines are open-drain: only pull low or release.
// - With forwarding on, traffic passes transparently to the downstream bus.
// - An alias address is rewritten to a target address downstream.
// - Works with bus pins unconnected, using strap and defaults only.
// - Register 0x00 bit 0 selects programmed bits 7:1 over the strap.
module scb_serial_control_bus_slave
  import scb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [STRAP_W-1:0]     addressSelectStrap,
  input  wire logic                   hostSclIn,
  input  wire logic                   hostSdaIn,
  output      scb_pkg::scb_od_t       hostScl,
  output      scb_pkg::scb_od_t       hostSda,
  input  wire logic                   dsSdaIn,
  output      scb_pkg::scb_od_t       dsScl,
  output      scb_pkg::scb_od_t       dsSda,
  output      logic [ADDR_W-1:0]      slaveAddr,
  output      logic                   busy
);
  import scb_pkg::*;

  scb_bus_t             bus;
  scb_bus_t             busPrev;
  logic                 dsSdaS;
  logic [STRAP_W-1:0]   strapS;
  logic [STRAP_W-1:0]   strapLevel;
  logic [2:0]           strapCnt;
  logic                 strapDone;
  logic [BYTE_W-1:0]    regs [REG_N];
  scb_state_t           state;
  logic [3:0]           bitCnt;
  logic [BYTE_W-1:0]    shiftIn;
  logic [BYTE_W-1:0]    txByte;
  logic [BYTE_W-1:0]    ptr;
  logic                 slaveOe;
  logic                 ackPhase;
  logic                 masterAck;
  logic                 aliasPre;
  logic                 fwdRw;
  logic                 fwdInAddr;
  logic                 fwdSlave;
  logic                 sclRise;
  logic                 sclFall;
  logic                 startDet;
  logic                 stopDet;
  logic                 fwdEn;
  logic                 dsBit;
  logic [ADDR_W-1:0]    strapAddr;
  logic [BYTE_W-1:0]    fullByte;
  logic [2:0]           bitIx;
  logic [2:0]           ptrIdx;
  logic [1:0]           dsOeHist;

  // Register offset decode, used by reads and writes
  function automatic logic [2:0] regIdx(input logic [BYTE_W-1:0] off);
    case (off)
      REG_ID:     regIdx = {1'b1, IX_ID};
      REG_ALIAS:  regIdx = {1'b1, IX_ALIAS};
      REG_TARGET: regIdx = {1'b1, IX_TARGET};
      REG_FWD:    regIdx = {1'b1, IX_FWD};
      default:    regIdx = 3'h0;
    endcase
  endfunction

  scb_sync #(.WIDTH(3)) uSyncBus (
    .clk  (clk),
    .rst  (rst),
    .din  ({hostSclIn, hostSdaIn, dsSdaIn}),
    .dout ({bus.scl, bus.sda, dsSdaS})
  );

  scb_sync #(.WIDTH(STRAP_W)) uSyncStrap (
    .clk  (clk),
    .rst  (rst),
    .din  (addressSelectStrap),
    .dout (strapS)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busPrev <= '1;
    end else begin
      busPrev <= bus;
    end
  end

  assign sclRise  = bus.scl && !busPrev.scl;
  assign sclFall  = !bus.scl && busPrev.scl;
  assign startDet = bus.scl && busPrev.scl && busPrev.sda && !bus.sda;
  assign stopDet  = bus.scl && busPrev.scl && !busPrev.sda && bus.sda;
  assign fullByte = {shiftIn[BYTE_W-2:0], bus.sda};
  assign bitIx    = 3'(BIT_LAST - bitCnt);
  assign fwdEn    = regs[IX_FWD][FWD_EN_BIT];
  assign ptrIdx   = regIdx(ptr);

  // Strap captured once after settling, held until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapCnt   <= '0;
      strapDone  <= 1'b0;
      strapLevel <= '0;
    end else if (!strapDone) begin
      strapCnt <= strapCnt + 3'h1;
      if (strapCnt == STRAP_SETTLE) begin
        strapLevel <= strapS;
        strapDone  <= 1'b1;
      end
    end
  end

  assign strapAddr = STRAP_BASE + 7'(strapLevel) * STRAP_STEP;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slaveAddr <= STRAP_BASE;
    end else if (regs[IX_ID][ID_SEL_BIT]) begin
      slaveAddr <= regs[IX_ID][BYTE_W-1:1];
    end else begin
      slaveAddr <= strapAddr;
    end
  end

  // Transfer state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= S_IDLE;
      bitCnt    <= '0;
      shiftIn   <= '0;
      txByte    <= '0;
      ptr       <= '0;
      slaveOe   <= 1'b0;
      ackPhase  <= 1'b0;
      masterAck <= 1'b0;
      aliasPre  <= 1'b1;
      fwdRw     <= 1'b0;
      fwdInAddr <= 1'b0;
      for (int i = 0; i < REG_N; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (startDet) begin
      state     <= S_ADDR;
      bitCnt    <= '0;
      slaveOe   <= 1'b0;
      ackPhase  <= 1'b0;
      aliasPre  <= 1'b1;
      fwdInAddr <= 1'b1;
    end else if (stopDet) begin
      state   <= S_IDLE;
      bitCnt  <= '0;
      slaveOe <= 1'b0;
    end else if (sclRise) begin
      shiftIn <= fullByte;
      case (state)
        S_ADDR: begin
          if (bitCnt < BIT_LAST) begin
            aliasPre <= aliasPre && (bus.sda == regs[IX_ALIAS][bitIx]);
          end
          bitCnt <= bitCnt + 4'h1;
          if (bitCnt == BIT_LAST) begin
            bitCnt <= BIT_ACK;
            fwdRw  <= bus.sda;
            if (shiftIn[ADDR_W-1:0] == slaveAddr) begin
              state <= S_AACK;
            end else if (fwdEn) begin
              state <= S_FWD;
            end else begin
              state <= S_IGN;
            end
          end
        end
        S_PTR, S_WDATA: begin
          bitCnt <= bitCnt + 4'h1;
          if (bitCnt == BIT_LAST) begin
            bitCnt <= '0;
            if (state == S_PTR) begin
              ptr   <= fullByte;
              state <= S_PACK;
            end else begin
              if (ptrIdx[2]) begin
                regs[ptrIdx[1:0]] <= fullByte;
              end
              ptr   <= ptr + 8'h01;
              state <= S_WACK;
            end
          end
        end
        S_RDATA: begin
          bitCnt <= bitCnt + 4'h1;
          if (bitCnt == BIT_LAST) begin
            state <= S_RACK;
          end
        end
        S_RACK: begin
          masterAck <= !bus.sda;
          ackPhase  <= 1'b1;
        end
        S_FWD: begin
          if (bitCnt == BIT_ACK) begin
            bitCnt    <= '0;
            fwdInAddr <= 1'b0;
          end else begin
            bitCnt <= bitCnt + 4'h1;
          end
        end
        default: begin
          bitCnt <= bitCnt;
        end
      endcase
    end else if (sclFall) begin
      case (state)
        S_AACK, S_PACK, S_WACK: begin
          if (!ackPhase) begin
            slaveOe  <= 1'b1;
            ackPhase <= 1'b1;
          end else begin
            ackPhase <= 1'b0;
            bitCnt   <= '0;
            if (state == S_AACK && fwdRw) begin
              txByte  <= ptrIdx[2] ? regs[ptrIdx[1:0]] : REG_RESET;
              slaveOe <= !(ptrIdx[2] && regs[ptrIdx[1:0]][BYTE_W-1]);
              ptr     <= ptr + 8'h01;
              state   <= S_RDATA;
            end else begin
              slaveOe <= 1'b0;
              state   <= (state == S_AACK) ? S_PTR : S_WDATA;
            end
          end
        end
        S_RDATA: begin
          slaveOe <= !txByte[bitIx];
        end
        S_RACK: begin
          if (!ackPhase) begin
            slaveOe <= 1'b0;
          end else if (masterAck) begin
            ackPhase <= 1'b0;
            bitCnt   <= '0;
            txByte   <= ptrIdx[2] ? regs[ptrIdx[1:0]] : REG_RESET;
            slaveOe  <= !(ptrIdx[2] && regs[ptrIdx[1:0]][BYTE_W-1]);
            ptr      <= ptr + 8'h01;
            state    <= S_RDATA;
          end else begin
            ackPhase <= 1'b0;
            slaveOe  <= 1'b0;
            state    <= S_IGN;
          end
        end
        default: begin
          slaveOe <= 1'b0;
        end
      endcase
    end
  end

  // Direction of a forwarded bit, updated while the clock is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwdSlave <= 1'b0;
    end else if (startDet || stopDet || state != S_FWD) begin
      fwdSlave <= 1'b0;
    end else if (sclFall) begin
      fwdSlave <= (bitCnt == BIT_ACK) ? (fwdInAddr || !fwdRw) : (fwdRw && !fwdInAddr);
    end
  end

  // Alias rewrite of the address bits sent downstream
  always_comb begin
    dsBit = bus.sda;
    if (state == S_ADDR && bitCnt < BIT_LAST && aliasPre && bus.sda == regs[IX_ALIAS][bitIx]) begin
      dsBit = regs[IX_TARGET][bitIx];
    end
  end

  // Own downstream drive history, masks its echo in the relay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dsOeHist <= '0;
    end else begin
      dsOeHist <= {dsOeHist[0], dsSda.oe};
    end
  end

  // Open-drain pin drives, low or released only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostScl <= '0;
      hostSda <= '0;
      dsScl   <= '0;
      dsSda   <= '0;
    end else begin
      hostScl.out <= 1'b0;
      hostScl.oe  <= 1'b0;
      hostSda.out <= 1'b0;
      hostSda.oe  <= slaveOe || (fwdSlave && !dsSda.oe && dsOeHist == 2'h0 && !dsSdaS);
      dsScl.out   <= 1'b0;
      dsScl.oe    <= fwdEn && !bus.scl;
      dsSda.out   <= 1'b0;
      dsSda.oe    <= fwdEn && !fwdSlave && !dsBit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != S_IDLE);
    end
  end

endmodule

// [sim/scb_chk.sv]
module scb_chk (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [2:0]       addressSelectStrap,
  input wire logic             hostSclIn,
  input wire logic             hostSdaIn,
  input wire scb_pkg::scb_od_t hostScl,
  input wire scb_pkg::scb_od_t hostSda,
  input wire logic             dsSdaIn,
  input wire scb_pkg::scb_od_t dsScl,
  input wire scb_pkg::scb_od_t dsSda,
  input wire logic [6:0]       slaveAddr,
  input wire logic             busy
);
  import scb_pkg::*;
  logic [4:0] sinceRst;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      sinceRst <= 5'h00;
    else if (sinceRst != 5'h1f)
      sinceRst <= sinceRst + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  drive_low_a: assert property (!hostSda.out && !dsScl.out && !dsSda.out)
    else $error("Open-drain output driven high");
  no_stretch_a: assert property (!hostScl.oe && !hostScl.out)
    else $error("Host clock line pulled");
  addr_map_a: assert property (sinceRst == 5'h0a |->
    slaveAddr == 7'h0c + {3'h0, addressSelectStrap, 1'b0}) else $error("Address not from strap");
  addr_hold_a: assert property (sinceRst > 5'h0b && !busy && !$past(busy) |-> $stable(slaveAddr))
    else $error("Address moved");
  start_busy_a: assert property ($fell(hostSdaIn) && hostSclIn && $past(hostSclIn) |-> ##[1:6] busy)
    else $error("Start not seen");
  stop_idle_a: assert property ($rose(hostSdaIn) && hostSclIn && $past(hostSclIn) |-> ##[1:6] !busy)
    else $error("Stop not seen");
  idle_release_a: assert property (hostSda.oe |-> busy || $past(busy))
    else $error("Data pulled while idle");
  ds_clock_a: assert property (dsScl.oe |->
    !$past(hostSclIn, 3) || !$past(hostSclIn, 4) || !$past(hostSclIn, 5)) else $error("Downstream clock stray");
  cover property ($rose(hostSda.oe));
  cover property ($fell(busy));
  cover property ($rose(dsScl.oe));
endmodule
bind scb_serial_control_bus_slave scb_chk i_chk (.clk(clk), .rst(rst), .addressSelectStrap(addressSelectStrap),
  .hostSclIn(hostSclIn), .hostSdaIn(hostSdaIn), .hostScl(hostScl), .hostSda(hostSda), .dsSdaIn(dsSdaIn),
  .dsScl(dsScl), .dsSda(dsSda), .slaveAddr(slaveAddr), .busy(busy));

// [sim/scb_host_model.sv]
module scb_host_model (
  input  wire logic clk,
  input  wire logic sclWire,
  input  wire logic sdaWire,
  output      logic sclOe,
  output      logic sdaOe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data falls while clock high, lines only pulled or released
  task automatic start();
    sdaOe = 1'b0;
    tick(4);
    sclOe = 1'b0;
    tick(4);
    sdaOe = 1'b1;
    tick(4);
    sclOe = 1'b1;
  endtask
  task automatic stop();
    tick(1);
    sdaOe = 1'b1;
    tick(3);
    sclOe = 1'b0;
    tick(4);
    sdaOe = 1'b0;
    tick(4);
  endtask
  task automatic bitx(input logic b, output logic r);
    tick(1);
    sdaOe = !b;
    tick(3);
    sclOe = 1'b0;
    tick(2);
    r = sdaWire;
    tick(2);
    sclOe = 1'b1;
  endtask
  // Ack level 0 asks for more, 1 ends a read
  task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(ackIn, ackOut);
  endtask
endmodule

// [sim/scb_serial_control_bus_slave_tb_top.sv]
module scb_serial_control_bus_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scb_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic       dsAck = 1'b0;
  logic       dsSeen = 1'b0;
  logic       sclOe, sdaOe, busy, ack;
  scb_od_t    hScl, hSda, dScl, dSda;
  logic [6:0] slaveAddr, own;
  logic [7:0] rx, d, al;
  logic [9:0] dsShift = 10'h000;
  wire        dsSclW = !dScl.oe;
  wire        sclW = !(sclOe || hScl.oe);
  wire        sdaW = !(sdaOe || hSda.oe);
  wire        dsSdaW = !(dSda.oe || dsAck);
  int         errTotal = 0;
  int         checksDone = 0;
  int         cycles = 0;
  int         seed = 59202;
  scb_serial_control_bus_slave i_dut (.clk(clk), .rst(rst), .addressSelectStrap(strap), .hostSclIn(sclW),
    .hostSdaIn(sdaW), .hostScl(hScl), .hostSda(hSda), .dsSdaIn(dsSdaW), .dsScl(dScl), .dsSda(dSda),
    .slaveAddr(slaveAddr), .busy(busy));
  scb_host_model i_host (.clk(clk), .sclWire(sclW), .sdaWire(sdaW), .sclOe(sclOe), .sdaOe(sdaOe));
  always #20 clk = ~clk;
  always @(posedge dsSclW)
    dsShift <= {dsShift[8:0], dsSdaW};
  always @(posedge clk) begin
    cycles++;
    if (dScl.oe === 1'b1)
      dsSeen <= 1'b1;
    if (cycles == 10000) begin
      errTotal++;
      closeOut();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic closeOut();
    $display("Checks %0d, errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic doReset(input logic [2:0] lv);
    @(negedge clk);
    rst = 1'b1;
    strap = lv;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (15) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] b, input logic expAck);
    i_host.xfer(b, 1'b1, rx, ack);
    cmp({7'h0, ack}, {7'h0, expAck});
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [7:0] v);
    i_host.start();
    put({own, 1'b0}, 1'b0);
    put(p, 1'b0);
    put(v, 1'b0);
    i_host.stop();
    repeat (8) @(negedge clk);
    cmp({7'h0, busy}, 8'h00);
  endtask
  task automatic rdReg(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
    i_host.start();
    put({own, 1'b0}, 1'b0);
    put(p, 1'b0);
    i_host.start();
    put({own, 1'b1}, 1'b0);
    i_host.xfer(8'hff, 1'b0, rx, ack);
    cmp(rx, e0);
    i_host.xfer(8'hff, 1'b1, rx, ack);
    cmp(rx, e1);
    i_host.stop();
  endtask
  initial begin
    for (int lv = 0; lv < 8; lv++) begin
      doReset(3'(lv));
      cmp({1'b0, slaveAddr}, 8'h0c + 8'(2 * lv));
      cmp({7'h0, busy}, 8'h00);
    end
    d = 8'($random(seed));
    doReset(d[2:0]);
    own = 7'h0c + {3'h0, d[2:0], 1'b0};
    strap = ~strap;
    repeat (10) @(negedge clk);
    cmp({1'b0, slaveAddr}, {1'b0, own});
    wrReg(REG_FWD, 8'h01);
    al = 8'($random(seed)) & 8'hfe;
    if (al[7:1] == own)
      al = al ^ 8'h04;
    wrReg(REG_ALIAS, al);
    rdReg(REG_ALIAS, al, 8'h00);
    rdReg(REG_FWD, 8'h01, 8'h00);
    dsSeen = 1'b0;
    repeat (3) begin
      d = 8'($random(seed)) & 8'hfe;
      if (d[7:1] == own)
        d = d ^ 8'h04;
      i_host.start();
      put(d, 1'b1);
      put(8'($random(seed)), 1'b1);
      i_host.stop();
    end
    cmp({7'h0, dsSeen}, 8'h01);
    wrReg(REG_TARGET, 8'h5a);
    i_host.start();
    put(al, 1'b1);
    i_host.stop();
    cmp(dsShift[9:2], 8'h5a);
    wrReg(REG_FWD, 8'h00);
    i_host.start();
    put(d, 1'b1);
    put(8'($random(seed)), 1'b1);
    i_host.stop();
    repeat (8) @(negedge clk);
    cmp({7'h0, busy}, 8'h00);
    wrReg(REG_ID, 8'h6b);
    repeat (4) @(negedge clk);
    cmp({1'b0, slaveAddr}, 8'h35);
    closeOut();
  end
endmodule
